// ===== hdl/tx_lane_control_regs_defines.svh
// Register offsets, field positions, masks and reset values for the lane control bank
`ifndef TX_LANE_CONTROL_REGS_DEFINES_SVH
`define TX_LANE_CONTROL_REGS_DEFINES_SVH

// ============================================================
// Register byte offsets
`define LANE_SIX_CONTROL_OFFSET     12'h01C
`define LANE_SEVEN_CONTROL_OFFSET   12'h020
`define LINK_LAYER_CONTROL_OFFSET   12'h050

// ============================================================
// Lane control register fields
`define LANE_INVERT_BIT             0
`define LANE_SLEEP_BIT              1
`define LANE_SPARE_LSB              2
`define LANE_SPARE_MSB              9
`define LANE_WRITABLE_MASK          32'h0000_03FF
`define LANE_CONTROL_RESET          32'h0000_0000

// ============================================================
// Link layer control register fields held by this bank
`define LINK_SPARE_A_BIT            14
`define LINK_SPARE_B_BIT            15
`define LINK_SPARE_C_BIT            16
`define LINK_WRITABLE_MASK          32'h0001_C000
`define LINK_CONTROL_RESET          32'h0000_0000

// ============================================================
// Bus and lane data widths
`define APB_ADDR_WIDTH              12
`define APB_DATA_WIDTH              32
`define LANE_DATA_WIDTH             32

`endif

// ===== hdl/tx_lane_control_regs_pkg.sv
// Types shared by the lane control register bank
package tx_lane_control_regs_pkg;

    // ============================================================
    // Register select decoded from the APB address
    typedef enum logic [1:0] {
        sel_none  = 2'h0,
        sel_lane6 = 2'h1,
        sel_lane7 = 2'h3,
        sel_link  = 2'h2
    } reg_sel_t;

endpackage

// ===== hdl/tx_lane_control_regs.sv
// APB register bank for upper transmit lane control and link layer spare bits
//
// Functional notes
// R1 - Lane power-down vector bit 6 comes straight from lane six sleep bit.
// R2 - Lane power-down vector bit 7 comes straight from lane seven sleep bit.
// R3 - Sleep bit: 0 normal, 1 powered down; resets to 0.
// R4 - Transport layer uses exported sleep bits to pick dropped lanes on fallback.
// R5 - Outside logic should mask lane receive resets with the sleep bits.
// R6 - Bit 0 of lane six register selects inverted polarity; resets to 0.
// R7 - Bit 0 of lane seven register selects inverted polarity; resets to 0.
// R8 - While invert is set, every transmitted data bit on that lane is inverted.
// R9 - Lane register bits 9:2 are read/write spare bits, no effect, reset zero.
// R10 - Link register bits 16, 15, 14 are read/write spare bits, reset zero.
// R11 - Upper reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`include "tx_lane_control_regs_defines.svh"

module tx_lane_control_regs (
    input  wire logic                          clk_sys_in,
    input  wire logic                          rstn_in,
    // APB slave
    input  wire logic                          psel_in,
    input  wire logic                          penable_in,
    input  wire logic                          pwrite_in,
    input  wire logic [`APB_ADDR_WIDTH-1:0]    paddr_in,
    input  wire logic [`APB_DATA_WIDTH-1:0]    pwdata_in,
    input  wire logic [3:0]                    pstrb_in,
    output logic      [`APB_DATA_WIDTH-1:0]    prdata_out,
    output logic                               pready_out,
    output logic                               pslverr_out,
    // Lane power-down vector, upper lanes only
    output logic      [7:6]                    lane_sleep_vec_out,
    // Polarity selects for the upper lanes
    output logic                               lane_six_invert_out,
    output logic                               lane_seven_invert_out,
    // Link layer spare bits
    output logic      [2:0]                    link_spare_out,
    // Transmit lane data path
    input  wire logic [`LANE_DATA_WIDTH-1:0]   lane_six_data_in,
    input  wire logic                          lane_six_valid_in,
    input  wire logic [`LANE_DATA_WIDTH-1:0]   lane_seven_data_in,
    input  wire logic                          lane_seven_valid_in,
    output logic      [`LANE_DATA_WIDTH-1:0]   lane_six_data_out,
    output logic                               lane_six_valid_out,
    output logic      [`LANE_DATA_WIDTH-1:0]   lane_seven_data_out,
    output logic                               lane_seven_valid_out
);

    // ============================================================
    // Helper functions

    // Map a word address onto one of the implemented registers
    // Exact match only, so an unaligned byte address is unmapped
    function automatic tx_lane_control_regs_pkg::reg_sel_t decode_addr(
        input logic [`APB_ADDR_WIDTH-1:0] addr
    );
        tx_lane_control_regs_pkg::reg_sel_t sel;
        sel = tx_lane_control_regs_pkg::sel_none;
        unique case (addr)
            `LANE_SIX_CONTROL_OFFSET: begin
                sel = tx_lane_control_regs_pkg::sel_lane6;
            end
            `LANE_SEVEN_CONTROL_OFFSET: begin
                sel = tx_lane_control_regs_pkg::sel_lane7;
            end
            `LINK_LAYER_CONTROL_OFFSET: begin
                sel = tx_lane_control_regs_pkg::sel_link;
            end
            default: begin
                sel = tx_lane_control_regs_pkg::sel_none;
            end
        endcase
        return sel;
    endfunction

    // Byte-lane merge of write data; bits outside the mask stay zero
    function automatic logic [`APB_DATA_WIDTH-1:0] merge_write(
        input logic [`APB_DATA_WIDTH-1:0] old_val,
        input logic [`APB_DATA_WIDTH-1:0] wdata,
        input logic [3:0]                 strb,
        input logic [`APB_DATA_WIDTH-1:0] mask
    );
        logic [`APB_DATA_WIDTH-1:0] result;
        integer                     i;
        result = old_val;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                result[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return result & mask;
    endfunction

    // Inverts a lane word when its polarity select is set
    function automatic logic [`LANE_DATA_WIDTH-1:0] apply_polarity(
        input logic [`LANE_DATA_WIDTH-1:0] data,
        input logic                        invert
    );
        return data ^ {`LANE_DATA_WIDTH{invert}};
    endfunction

    // True when the decoded select names a register held in this bank
    function automatic logic is_mapped(
        input tx_lane_control_regs_pkg::reg_sel_t sel
    );
        return sel != tx_lane_control_regs_pkg::sel_none;
    endfunction

    // Field pickers; the invert bit feeds an output and the data path, so one
    // definition keeps the two from drifting apart
    function automatic logic sleep_of(
        input logic [`APB_DATA_WIDTH-1:0] word
    );
        return word[`LANE_SLEEP_BIT];
    endfunction

    function automatic logic invert_of(
        input logic [`APB_DATA_WIDTH-1:0] word
    );
        return word[`LANE_INVERT_BIT];
    endfunction

    // Link spare bits packed as {bit 16, bit 15, bit 14}
    function automatic logic [2:0] link_spares_of(
        input logic [`APB_DATA_WIDTH-1:0] word
    );
        return {word[`LINK_SPARE_C_BIT], word[`LINK_SPARE_B_BIT], word[`LINK_SPARE_A_BIT]};
    endfunction

    // Bus image of one register; reserved bits are masked on the way out as
    // well as on the way in, so they read as zero whatever storage holds
    function automatic logic [`APB_DATA_WIDTH-1:0] read_view(
        input tx_lane_control_regs_pkg::reg_sel_t sel,
        input logic [`APB_DATA_WIDTH-1:0]         six_val,
        input logic [`APB_DATA_WIDTH-1:0]         seven_val,
        input logic [`APB_DATA_WIDTH-1:0]         link_val
    );
        logic [`APB_DATA_WIDTH-1:0] view;
        view = '0;
        unique case (sel)
            tx_lane_control_regs_pkg::sel_lane6: begin
                view = six_val & `LANE_WRITABLE_MASK; // [R11]
            end
            tx_lane_control_regs_pkg::sel_lane7: begin
                view = seven_val & `LANE_WRITABLE_MASK; // [R11]
            end
            tx_lane_control_regs_pkg::sel_link: begin
                view = link_val & `LINK_WRITABLE_MASK; // [R11]
            end
            tx_lane_control_regs_pkg::sel_none: begin
                view = '0;
            end
        endcase
        return view;
    endfunction

    // ============================================================
    // Register storage
    // Lane six: invert, sleep and spare bits
    logic [`APB_DATA_WIDTH-1:0] lane_six_control_reg;
    logic [`APB_DATA_WIDTH-1:0] lane_six_control_next;
    // Lane seven: same layout as lane six
    logic [`APB_DATA_WIDTH-1:0] lane_seven_control_reg;
    logic [`APB_DATA_WIDTH-1:0] lane_seven_control_next;
    // Link layer control: spare bits 16:14 only
    logic [`APB_DATA_WIDTH-1:0] link_layer_control_reg;
    logic [`APB_DATA_WIDTH-1:0] link_layer_control_next;
    // Read data, a flop so prdata never glitches during access
    logic [`APB_DATA_WIDTH-1:0] prdata_reg;
    logic [`APB_DATA_WIDTH-1:0] prdata_next;

    tx_lane_control_regs_pkg::reg_sel_t bus_sel;
    logic                               setup_phase;
    logic                               access_done;
    logic                               write_done;
    logic                               lane_six_write;
    logic                               lane_seven_write;
    logic                               link_write;

    // ============================================================
    // APB decode
    assign bus_sel     = decode_addr(paddr_in);
    // Setup-phase capture still sees a write from the transfer just before,
    // because that write landed on the previous edge
    assign setup_phase = psel_in & ~penable_in;
    // Zero wait states: every access phase completes on its first edge
    assign access_done = psel_in & penable_in;
    assign write_done  = access_done & pwrite_in & is_mapped(bus_sel);
    // One strobe per register, so each register's process sees only its own hit
    assign lane_six_write   = write_done & (bus_sel == tx_lane_control_regs_pkg::sel_lane6);
    assign lane_seven_write = write_done & (bus_sel == tx_lane_control_regs_pkg::sel_lane7);
    assign link_write       = write_done & (bus_sel == tx_lane_control_regs_pkg::sel_link);

    assign pready_out  = 1'b1;
    // Unmapped addresses are flagged rather than silently absorbed
    assign pslverr_out = access_done & ~is_mapped(bus_sel);

    // ============================================================
    // Lane six control register
    // Each register has its own processes, so a decode slip on one address
    // cannot disturb the bits held for another
    always_comb begin
        lane_six_control_next = lane_six_control_reg;
        if (lane_six_write) begin
            // Invert, sleep and spare bits written; bits 31:10 dropped [R3] [R6] [R9] [R11]
            lane_six_control_next = merge_write(lane_six_control_reg, pwdata_in,
                                                pstrb_in, `LANE_WRITABLE_MASK);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            lane_six_control_reg <= `LANE_CONTROL_RESET; // [R3] [R6] [R9]
        end else begin
            lane_six_control_reg <= lane_six_control_next;
        end
    end

    // ============================================================
    // Lane seven control register
    always_comb begin
        lane_seven_control_next = lane_seven_control_reg;
        if (lane_seven_write) begin
            // Same layout as lane six [R3] [R7] [R9] [R11]
            lane_seven_control_next = merge_write(lane_seven_control_reg, pwdata_in,
                                                  pstrb_in, `LANE_WRITABLE_MASK);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            lane_seven_control_reg <= `LANE_CONTROL_RESET; // [R3] [R7] [R9]
        end else begin
            lane_seven_control_reg <= lane_seven_control_next;
        end
    end

    // ============================================================
    // Link layer control register
    // Only bits 16:14 live in this bank; the other fields of the register are
    // held elsewhere and read back as zero here
    always_comb begin
        link_layer_control_next = link_layer_control_reg;
        if (link_write) begin
            // Only the three spare bits are held here [R10] [R11]
            link_layer_control_next = merge_write(link_layer_control_reg, pwdata_in,
                                                  pstrb_in, `LINK_WRITABLE_MASK);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            link_layer_control_reg <= `LINK_CONTROL_RESET; // [R10]
        end else begin
            link_layer_control_reg <= link_layer_control_next;
        end
    end

    // ============================================================
    // Read data
    // Captured in the setup phase so prdata is a flop output during access
    always_comb begin
        prdata_next = prdata_reg;
        if (setup_phase) begin
            prdata_next = read_view(bus_sel, lane_six_control_reg, lane_seven_control_reg,
                                    link_layer_control_reg); // [R11]
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            prdata_reg <= '0;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata_out = prdata_reg;

    // ============================================================
    // Exported control bits
    // Driven straight from storage so the transport layer and reset masks
    // see a change on the edge after the write, with no extra pipeline
    assign lane_sleep_vec_out[6] = sleep_of(lane_six_control_reg);         // [R1] [R4]
    assign lane_sleep_vec_out[7] = sleep_of(lane_seven_control_reg);       // [R2] [R4]
    assign lane_six_invert_out   = invert_of(lane_six_control_reg);        // [R6]
    assign lane_seven_invert_out = invert_of(lane_seven_control_reg);      // [R7]
    assign link_spare_out        = link_spares_of(link_layer_control_reg); // [R10]

    // ============================================================
    // Lane data path
    // One register stage; a polarity change applies from the next word on,
    // so a word may straddle the change but is never half inverted
    logic [`LANE_DATA_WIDTH-1:0] lane_six_data_reg;
    logic [`LANE_DATA_WIDTH-1:0] lane_six_data_next;
    logic [`LANE_DATA_WIDTH-1:0] lane_seven_data_reg;
    logic [`LANE_DATA_WIDTH-1:0] lane_seven_data_next;
    logic                        lane_six_valid_reg;
    logic                        lane_six_valid_next;
    logic                        lane_seven_valid_reg;
    logic                        lane_seven_valid_next;

    // ============================================================
    // Lane six data stage
    // Valid rides beside the data so a word never meets a stale qualifier
    always_comb begin
        lane_six_data_next  = apply_polarity(lane_six_data_in,
                                             invert_of(lane_six_control_reg)); // [R8]
        lane_six_valid_next = lane_six_valid_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            lane_six_data_reg  <= '0;
            lane_six_valid_reg <= 1'b0;
        end else begin
            lane_six_data_reg  <= lane_six_data_next;
            lane_six_valid_reg <= lane_six_valid_next;
        end
    end

    // ============================================================
    // Lane seven data stage
    always_comb begin
        lane_seven_data_next  = apply_polarity(lane_seven_data_in,
                                               invert_of(lane_seven_control_reg)); // [R8]
        lane_seven_valid_next = lane_seven_valid_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            lane_seven_data_reg  <= '0;
            lane_seven_valid_reg <= 1'b0;
        end else begin
            lane_seven_data_reg  <= lane_seven_data_next;
            lane_seven_valid_reg <= lane_seven_valid_next;
        end
    end

    assign lane_six_data_out    = lane_six_data_reg;
    assign lane_seven_data_out  = lane_seven_data_reg;
    assign lane_six_valid_out   = lane_six_valid_reg;
    assign lane_seven_valid_out = lane_seven_valid_reg;

endmodule

// ===== tb/tx_lane_control_regs_monitor.sv
// Assertion checker for the lane control register bank
`timescale 1ns/1ps
// ==========
// Checker
module tx_lane_control_regs_monitor (
    input wire logic        clk_sys_in,
    input wire logic        rstn_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pslverr_out,
    input wire logic [7:6]  lane_sleep_vec_out,
    input wire logic        lane_six_invert_out,
    input wire logic        lane_seven_invert_out,
    input wire logic [2:0]  link_spare_out,
    input wire logic [31:0] lane_six_data_in,
    input wire logic [31:0] lane_six_data_out,
    input wire logic        lane_seven_valid_in,
    input wire logic        lane_seven_valid_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    logic acc;
    logic wr;
    assign acc = psel_in && penable_in;
    assign wr  = acc && pwrite_in;
    sleep6_a: assert property (wr && paddr_in == 12'h01C && pstrb_in[0] |=>
        lane_sleep_vec_out[6] == $past(pwdata_in[1])) else $error("lane six sleep wrong");
    sleep7_a: assert property (wr && paddr_in == 12'h020 && pstrb_in[0] |=>
        lane_sleep_vec_out[7] == $past(pwdata_in[1])) else $error("lane seven sleep wrong");
    invert6_a: assert property (wr && paddr_in == 12'h01C && pstrb_in[0] |=>
        lane_six_invert_out == $past(pwdata_in[0])) else $error("lane six invert wrong");
    invert7_a: assert property (wr && paddr_in == 12'h020 && pstrb_in[0] |=>
        lane_seven_invert_out == $past(pwdata_in[0])) else $error("lane seven invert wrong");
    spare_a: assert property (wr && paddr_in == 12'h050 && pstrb_in[2:1] == 2'h3 |=>
        link_spare_out == $past(pwdata_in[16:14])) else $error("link spare bits wrong");
    sleep_hold_a: assert property (!wr |=> $stable(lane_sleep_vec_out))
        else $error("sleep vector moved without write");
    data_six_a: assert property ($past(rstn_in) |-> lane_six_data_out ==
        ($past(lane_six_data_in) ^ {32{$past(lane_six_invert_out)}})) else $error("lane six data");
    valid_seven_a: assert property ($past(rstn_in) |->
        lane_seven_valid_out == $past(lane_seven_valid_in)) else $error("lane seven valid");
    unmapped_read_a: assert property (acc && !(paddr_in inside {12'h01C, 12'h020, 12'h050})
        |-> pslverr_out && prdata_out == 32'h0) else $error("unmapped access answer wrong");
    lane_read_a: assert property (acc && !pwrite_in && paddr_in == 12'h020 |->
        prdata_out[31:10] == 22'h0 && prdata_out[1:0] ==
        {lane_sleep_vec_out[7], lane_seven_invert_out}) else $error("lane seven read wrong");
    cover property (wr && paddr_in == 12'h01C);
    cover property (acc && pslverr_out);
    cover property (lane_six_invert_out && lane_seven_valid_out);
endmodule
bind tx_lane_control_regs tx_lane_control_regs_monitor u_mon (.clk_sys_in, .rstn_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pslverr_out,
    .lane_sleep_vec_out, .lane_six_invert_out, .lane_seven_invert_out, .link_spare_out,
    .lane_six_data_in, .lane_six_data_out, .lane_seven_valid_in, .lane_seven_valid_out);

// ===== tb/tb_top.sv
// Self-checking bench for the lane control register bank
`timescale 1ns/1ps
`include "tx_lane_control_regs_defines.svh"
// ==========
// Bench top
module tb_top;
    logic        clk_sys_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, lane_six_data_in, lane_seven_data_in;
    logic [31:0] lane_six_data_out, lane_seven_data_out, rd;
    logic [3:0]  pstrb_in;
    logic [7:6]  lane_sleep_vec_out;
    logic [2:0]  link_spare_out;
    logic        lane_six_invert_out, lane_seven_invert_out, lane_six_valid_in, er;
    logic        lane_seven_valid_in, lane_six_valid_out, lane_seven_valid_out;
    int          num_errors = 0;
    int          checks = 0;

    tx_lane_control_regs u_dut (.clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
        .lane_sleep_vec_out, .lane_six_invert_out, .lane_seven_invert_out, .link_spare_out,
        .lane_six_data_in, .lane_six_valid_in, .lane_seven_data_in, .lane_seven_valid_in,
        .lane_six_data_out, .lane_six_valid_out, .lane_seven_data_out, .lane_seven_valid_out);

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One transfer, then one idle cycle so no signal is driven twice in a time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (pready_out !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                         input logic e);
        apb(1'b0, a, 32'h0, 4'hF);
        check(nm, rd, exp);
        check(nm, {31'h0, er}, {31'h0, e});
    endtask

    task automatic reset_values();
        rdchk("lane6 reset", `LANE_SIX_CONTROL_OFFSET, 32'h0, 1'b0);
        rdchk("lane7 reset", `LANE_SEVEN_CONTROL_OFFSET, 32'h0, 1'b0);
        rdchk("link reset", `LINK_LAYER_CONTROL_OFFSET, 32'h0, 1'b0);
        check("sleep reset", {30'h0, lane_sleep_vec_out}, 32'h0);
    endtask

    task automatic lane_fields();
        apb(1'b1, `LANE_SIX_CONTROL_OFFSET, 32'hFFFF_FFFF, 4'hF);
        apb(1'b1, `LANE_SEVEN_CONTROL_OFFSET, 32'hFFFF_FC02, 4'hF);
        rdchk("lane6 ones", `LANE_SIX_CONTROL_OFFSET, 32'h0000_03FF, 1'b0);
        rdchk("lane7 sleep", `LANE_SEVEN_CONTROL_OFFSET, 32'h0000_0002, 1'b0);
        check("sleep vector", {30'h0, lane_sleep_vec_out}, 32'h3);
        check("invert six", {31'h0, lane_six_invert_out}, 32'h1);
        check("invert seven", {31'h0, lane_seven_invert_out}, 32'h0);
        apb(1'b1, `LANE_SIX_CONTROL_OFFSET, 32'h0, 4'h2);
        rdchk("lane6 strobe", `LANE_SIX_CONTROL_OFFSET, 32'h0000_00FF, 1'b0);
    endtask

    task automatic link_spares();
        apb(1'b1, `LINK_LAYER_CONTROL_OFFSET, 32'hFFFF_FFFF, 4'hF);
        rdchk("link ones", `LINK_LAYER_CONTROL_OFFSET, 32'h0001_C000, 1'b0);
        check("spare out", {29'h0, link_spare_out}, 32'h7);
        apb(1'b1, `LINK_LAYER_CONTROL_OFFSET, 32'h0000_8000, 4'h2);
        check("spare strobe", {29'h0, link_spare_out}, 32'h6);
    endtask

    task automatic unmapped();
        apb(1'b1, 12'h024, 32'hFFFF_FFFF, 4'hF);
        rdchk("unmapped", 12'h024, 32'h0, 1'b1);
        rdchk("misaligned", 12'h01D, 32'h0, 1'b1);
        rdchk("lane7 kept", `LANE_SEVEN_CONTROL_OFFSET, 32'h2, 1'b0);
    endtask

    task automatic data_path();
        lane_six_data_in <= 32'hA5A5_0F0F;
        lane_seven_data_in <= 32'h1234_5678;
        lane_six_valid_in <= 1'b1;
        lane_seven_valid_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        check("lane6 data", lane_six_data_out, 32'h5A5A_F0F0);
        check("lane7 data", lane_seven_data_out, 32'h1234_5678);
        check("lane7 valid", {31'h0, lane_seven_valid_out}, 32'h1);
        check("lane6 valid", {31'h0, lane_six_valid_out}, 32'h1);
        apb(1'b1, `LANE_SIX_CONTROL_OFFSET, 32'h0, 4'hF);
        @(posedge clk_sys_in);
        check("lane6 plain", lane_six_data_out, 32'hA5A5_0F0F);
        check("sleep cleared", {30'h0, lane_sleep_vec_out}, 32'h2);
        lane_six_valid_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        check("lane6 idle", {31'h0, lane_six_valid_out}, 32'h0);
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        rstn_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        pstrb_in = 4'h0;
        lane_six_data_in = 32'h0;
        lane_seven_data_in = 32'h0;
        lane_six_valid_in = 1'b0;
        lane_seven_valid_in = 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        reset_values();
        lane_fields();
        link_spares();
        unmapped();
        data_path();
        tally_and_finish();
    end
endmodule
